// >>> pkg/rbc_pkg.sv
// Shared constants and types for the reset and boot control block
package rbc_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   // Boot start delay after the hard reset bit clears, least of the allowed window
   localparam int HARD_RESET_BIT_BOOT_DLY_NS = 1000;
   localparam int HARD_RESET_BIT_BOOT_DLY_CYC =
      (HARD_RESET_BIT_BOOT_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TMR_W = 10;

   localparam logic [15:0] ADDR_MAIN_CONTROL_ONE = 16'h0001;
   localparam logic [15:0] ADDR_PINFN1 = 16'h000b;
   localparam logic [15:0] ADDR_PIN0SS = 16'h000d;
   localparam logic [15:0] ADDR_SLAVE = 16'h0011;
   localparam logic [15:0] ADDR_CONFIG_STATUS_REG = 16'h0040;
   localparam logic [15:0] ADDR_GLOB = 16'h0043;

   localparam int MAIN_CONTROL_ONE_SOFT_RESET_BIT_BIT = 7;
   localparam int MAIN_CONTROL_ONE_HARD_RESET_BIT_BIT = 6;
   localparam int GLOB_DONE_BIT = 7;
   localparam int GLOB_IE_BIT = 1;
   localparam int GLOB_EVT_BIT = 0;
   localparam int CFG_TEST_BIT = 5;
   localparam int CFG_DNV_BIT = 4;

   localparam logic [7:0] PINFN1_RST = 8'h00;
   localparam logic [7:0] PIN0SS_RST = 8'h00;
   localparam logic [6:0] SLAVE_RST = 7'h74;
   localparam logic [1:0] IF_EXT_NVM = 2'h3;
   localparam logic [2:0] AC_DNV = 3'h0;

   typedef enum logic [1:0] {RBC_EDGE_RISE, RBC_EDGE_FALL, RBC_EDGE_BOTH} rbc_edge_t;
   typedef enum logic [1:0] {RBC_SRC_NONE, RBC_SRC_ROM, RBC_SRC_EXT, RBC_SRC_INT} rbc_src_t;

   typedef struct packed {
      logic test;
      logic [2:0] cfg_sel;
      logic [1:0] if_sel;
   } rbc_pins_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } rbc_host_req_t;

   typedef struct packed {
      logic valid;
      rbc_src_t src;
      logic [2:0] image;
   } rbc_boot_req_t;

   typedef struct packed {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } rbc_nvm_wr_t;
endpackage

// >>> src/rbc_cycle_timer.sv
// Loadable down counter giving a one-cycle pulse after a set number of cycles
module rbc_cycle_timer #(
   parameter int W = 10
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic load,
   input wire logic cancel,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] cnt_reg;
   logic done_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         // Load wins over cancel so a restart in the clearing cycle survives
         if (load) begin
            cnt_reg <= count;
         end else if (cancel) begin
            cnt_reg <= '0;
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         done_reg <= !load && !cancel && (cnt_reg == W'(1));
      end
   end

   assign done = done_reg;

   // Expiry lands one edge after the count reaches one
   done_timing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cnt_reg == W'(1) && !load && !cancel |=> done)
      else $error("Timer did not expire on time");
endmodule // rbc_cycle_timer

// >>> src/rbc_w1c_flag.sv
// Latched status bit: set on a chosen edge, cleared by a write of one
module rbc_w1c_flag #(
   parameter rbc_pkg::rbc_edge_t EDGE = rbc_pkg::RBC_EDGE_RISE
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic sig,
   input wire logic w1c,
   output logic flag
);
   logic prev_reg;
   logic flag_reg;
   logic hit;

   always_comb begin
      unique case (EDGE)
         rbc_pkg::RBC_EDGE_RISE: hit = sig && !prev_reg;
         rbc_pkg::RBC_EDGE_FALL: hit = !sig && prev_reg;
         default: hit = sig != prev_reg;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         prev_reg <= sig;
         // Edge sets, one clears
         // A set in the write-of-one cycle wins so no event is lost; clear wins over a set
         if (clear) begin
            flag_reg <= 1'b0;
         end else begin
            flag_reg <= hit || (flag_reg && !w1c);
         end
      end
   end

   assign flag = flag_reg;

   flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      hit && !clear |=> flag)
      else $error("Edge did not set the flag");
   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      flag && w1c && !hit |=> !flag)
      else $error("Write of one did not clear the flag");
endmodule // rbc_w1c_flag

// >>> src/rbc_top.sv
// Reset, strap sampling and boot start control for the clock fanout core
// Summary of operation
// - Reset pin low asynchronously holds every register at its default.
// - Boot controller starts when the reset pin rises.
// - Hard reset clears all but host port, itself, slave address, interface mode.
// - During hard reset writes are taken, reads are refused.
// - Hard reset release resamples test and select pins, not interface pins.
// - Boot starts 1 to 3 us after hard reset clears.
// - Soft reset clears all but host port, both reset bits, address, status.
// - Soft reset never starts a boot.
// - ROM part with interface pins 00, 01, 10 boots ROM image.
// - ROM part with interface pins 11 boots the external memory image.
// - Internal memory part boots one of eight internal images.
// - Internal memory part with test, select 000, interface 11 at reset release enters direct write.
// - Direct write maps memory for writes, registers become inaccessible.
// - Direct write drives the MISO output continuously.
// - Writes to read-only fields are ignored.
// - Latched status bits set on their edge, clear on write of one.
// - Latched bit raises a request only while its enable is set.
// - Configuration fields return to defaults during covering resets.
module rbc_top #(
   parameter bit INT_NVM = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input rbc_pkg::rbc_pins_t pins,
   input rbc_pkg::rbc_host_req_t host,
   input wire logic boot_applied,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic rd_refused,
   output rbc_pkg::rbc_boot_req_t boot_req,
   output rbc_pkg::rbc_nvm_wr_t nvm_wr,
   output logic miso_oe,
   output logic boot_done,
   output logic irq_req
);
   typedef enum logic [1:0] {BT_IDLE, BT_RUN, BT_DONE} rbc_boot_st_t;

   localparam int HDLY = rbc_pkg::HARD_RESET_BIT_BOOT_DLY_CYC;

   logic started_reg;
   logic hard_reset_bit_reg;
   logic soft_reset_bit_reg;
   logic core_clr;
   logic reg_wr;
   logic reg_rd;
   logic wr_main_control_one;
   logic hard_reset_bit_fall;
   logic [7:0] pinfn1_reg;
   logic [7:0] pin0ss_reg;
   logic [6:0] slave_reg;
   logic [1:0] cfg_if_reg;
   logic cfg_test_reg;
   logic [2:0] cfg_ac_reg;
   logic dnv_reg;
   logic boot_go_reg;
   logic tmr_done;
   rbc_boot_st_t st_reg;
   rbc_pkg::rbc_src_t src;
   logic boot_done_reg;
   logic evt_flag;
   logic ie_reg;
   logic irq_reg;
   logic [7:0] rd_data_reg;
   logic rd_valid_reg;
   logic rd_refused_reg;
   logic miso_oe_reg;
   rbc_pkg::rbc_boot_req_t boot_req_reg;
   rbc_pkg::rbc_nvm_wr_t nvm_wr_reg;

   function automatic logic hit(input rbc_pkg::rbc_host_req_t r, input logic [15:0] a);
      return r.addr == a;
   endfunction

   function automatic rbc_pkg::rbc_src_t pick_src(input logic intn, input logic dnv,
                                                  input logic [1:0] ifs);
      if (dnv) begin
         return rbc_pkg::RBC_SRC_NONE;
      end
      if (intn) begin
         return rbc_pkg::RBC_SRC_INT;
      end
      if (ifs == rbc_pkg::IF_EXT_NVM) begin
         return rbc_pkg::RBC_SRC_EXT;
      end
      return rbc_pkg::RBC_SRC_ROM;
   endfunction

   assign reg_wr = host.wr && !dnv_reg;
   assign reg_rd = host.rd && !dnv_reg;
   assign wr_main_control_one = reg_wr && hit(host, rbc_pkg::ADDR_MAIN_CONTROL_ONE);
   assign hard_reset_bit_fall = hard_reset_bit_reg && wr_main_control_one && !host.wdata[rbc_pkg::MAIN_CONTROL_ONE_HARD_RESET_BIT_BIT];
   assign core_clr = hard_reset_bit_reg || soft_reset_bit_reg;

   // Boot start at release
   // Straps are caught on the first clocked edge after release, never under reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         started_reg <= 1'b0;
      end else begin
         started_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hard_reset_bit_reg <= 1'b0;
         soft_reset_bit_reg <= 1'b0;
      end else begin
         if (wr_main_control_one) begin
            hard_reset_bit_reg <= host.wdata[rbc_pkg::MAIN_CONTROL_ONE_HARD_RESET_BIT_BIT];
         end
         // Hard reset clears the soft bit
         if (hard_reset_bit_reg) begin
            soft_reset_bit_reg <= 1'b0;
         end else if (wr_main_control_one) begin
            soft_reset_bit_reg <= host.wdata[rbc_pkg::MAIN_CONTROL_ONE_SOFT_RESET_BIT_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_if_reg <= 2'h0;
         cfg_test_reg <= 1'b0;
         cfg_ac_reg <= 3'h0;
         dnv_reg <= 1'b0;
      end else if (!started_reg) begin
         cfg_if_reg <= pins.if_sel;
         cfg_test_reg <= pins.test;
         cfg_ac_reg <= pins.cfg_sel;
         // Only the internal memory part has a memory to write directly
         dnv_reg <= INT_NVM && pins.test && pins.cfg_sel == rbc_pkg::AC_DNV &&
                    pins.if_sel == rbc_pkg::IF_EXT_NVM;
      end else if (hard_reset_bit_fall) begin
         cfg_test_reg <= pins.test;
         cfg_ac_reg <= pins.cfg_sel;
      end else if (hard_reset_bit_reg) begin
         cfg_test_reg <= 1'b0;
         cfg_ac_reg <= 3'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinfn1_reg <= rbc_pkg::PINFN1_RST;
         pin0ss_reg <= rbc_pkg::PIN0SS_RST;
         ie_reg <= 1'b0;
      end else if (core_clr) begin
         pinfn1_reg <= rbc_pkg::PINFN1_RST;
         pin0ss_reg <= rbc_pkg::PIN0SS_RST;
         ie_reg <= 1'b0;
      end else if (reg_wr) begin
         if (hit(host, rbc_pkg::ADDR_PINFN1)) begin
            pinfn1_reg <= host.wdata;
         end
         if (hit(host, rbc_pkg::ADDR_PIN0SS)) begin
            pin0ss_reg <= host.wdata;
         end
         if (hit(host, rbc_pkg::ADDR_GLOB)) begin
            ie_reg <= host.wdata[rbc_pkg::GLOB_IE_BIT];
         end
      end
   end

   // Slave address survives both core resets
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         slave_reg <= rbc_pkg::SLAVE_RST;
      end else if (reg_wr && hit(host, rbc_pkg::ADDR_SLAVE)) begin
         slave_reg <= host.wdata[6:0];
      end
   end

   rbc_cycle_timer #(
      .W(rbc_pkg::TMR_W)
   ) u_tmr (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .load(hard_reset_bit_fall),
      .cancel(soft_reset_bit_reg),
      .count(rbc_pkg::TMR_W'(HDLY)),
      .done(tmr_done)
   );

   // Soft reset never arms a start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         boot_go_reg <= 1'b0;
      end else begin
         boot_go_reg <= !started_reg || (tmr_done && !core_clr);
      end
   end

   assign src = pick_src(INT_NVM, dnv_reg, cfg_if_reg);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= BT_IDLE;
         boot_done_reg <= 1'b0;
         boot_req_reg <= '0;
      end else if (core_clr) begin
         st_reg <= BT_IDLE;
         boot_done_reg <= 1'b0;
         boot_req_reg <= '0;
      end else begin
         unique case (st_reg)
            BT_IDLE: begin
               if (boot_go_reg && src == rbc_pkg::RBC_SRC_NONE) begin
                  st_reg <= BT_DONE;
                  boot_done_reg <= 1'b1;
               end else if (boot_go_reg) begin
                  st_reg <= BT_RUN;
                  boot_done_reg <= 1'b0;
                  boot_req_reg <= '{valid: 1'b1, src: src, image: cfg_ac_reg};
               end
            end
            BT_RUN: begin
               if (boot_applied) begin
                  st_reg <= BT_DONE;
                  boot_done_reg <= 1'b1;
                  boot_req_reg.valid <= 1'b0;
               end
            end
            BT_DONE: begin
               st_reg <= BT_DONE;
            end
         endcase
      end
   end

   rbc_w1c_flag #(
      .EDGE(rbc_pkg::RBC_EDGE_RISE)
   ) u_evt (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clear(core_clr),
      .sig(boot_done_reg),
      .w1c(reg_wr && hit(host, rbc_pkg::ADDR_GLOB) && host.wdata[rbc_pkg::GLOB_EVT_BIT]),
      .flag(evt_flag)
   );

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= evt_flag && ie_reg;
      end
   end

   // Read-only fields return live state only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
         rd_refused_reg <= 1'b0;
      end else begin
         rd_valid_reg <= reg_rd && !hard_reset_bit_reg;
         rd_refused_reg <= host.rd && (hard_reset_bit_reg || dnv_reg);
         rd_data_reg <= 8'h00;
         if (reg_rd && !hard_reset_bit_reg) begin
            unique case (host.addr)
               rbc_pkg::ADDR_MAIN_CONTROL_ONE: rd_data_reg <= {soft_reset_bit_reg, hard_reset_bit_reg, 6'h00};
               rbc_pkg::ADDR_PINFN1: rd_data_reg <= pinfn1_reg;
               rbc_pkg::ADDR_PIN0SS: rd_data_reg <= pin0ss_reg;
               rbc_pkg::ADDR_SLAVE: rd_data_reg <= {1'b0, slave_reg};
               rbc_pkg::ADDR_CONFIG_STATUS_REG: rd_data_reg <= {cfg_if_reg, cfg_test_reg, dnv_reg,
                                                     1'b0, cfg_ac_reg};
               rbc_pkg::ADDR_GLOB: rd_data_reg <= {boot_done_reg, 5'h00, ie_reg, evt_flag};
               default: rd_data_reg <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nvm_wr_reg <= '0;
         miso_oe_reg <= 1'b0;
      end else begin
         nvm_wr_reg <= '{en: host.wr && dnv_reg, addr: host.addr, data: host.wdata};
         miso_oe_reg <= dnv_reg;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign rd_refused = rd_refused_reg;
   assign boot_req = boot_req_reg;
   assign nvm_wr = nvm_wr_reg;
   assign miso_oe = miso_oe_reg;
   assign boot_done = boot_done_reg;
   assign irq_req = irq_reg;

   default clocking dflt_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   por_boot_a: assert property ($rose(started_reg) |=> st_reg != BT_IDLE)
      else $error("Boot did not start after reset release");
   hard_reset_bit_delay_a: assert property (hard_reset_bit_fall ##1 !soft_reset_bit_reg |-> ##HDLY tmr_done)
      else $error("Boot start delay after hard reset is wrong");
   hard_reset_bit_read_a: assert property (host.rd && hard_reset_bit_reg |=> rd_refused && !rd_valid)
      else $error("Read served during hard reset");
   if_keep_a: assert property (started_reg && hard_reset_bit_reg |=> $stable(cfg_if_reg))
      else $error("Interface mode changed in hard reset");
   slave_keep_a: assert property (core_clr && !(reg_wr && hit(host, rbc_pkg::ADDR_SLAVE))
      |=> $stable(slave_reg))
      else $error("Slave address lost in core reset");
   soft_reset_bit_noboot_a: assert property (soft_reset_bit_reg ##1 soft_reset_bit_reg |-> st_reg == BT_IDLE
      && !boot_done_reg && !boot_req_reg.valid)
      else $error("Boot active under soft reset");
   dnv_write_a: assert property (host.wr && dnv_reg |=> nvm_wr_reg.en
      && $stable(pinfn1_reg) && $stable(hard_reset_bit_reg))
      else $error("Direct write did not reach memory");
   miso_hold_a: assert property (started_reg && dnv_reg |=> miso_oe_reg [*2])
      else $error("MISO released in direct write");
   boot_done_a: assert property (st_reg == BT_RUN && boot_applied && !core_clr
      |=> boot_done_reg && !boot_req_reg.valid)
      else $error("Boot done not set after image applied");
   ro_write_a: assert property (reg_wr && hit(host, rbc_pkg::ADDR_CONFIG_STATUS_REG) && !hard_reset_bit_reg
      |=> $stable(cfg_ac_reg) && $stable(cfg_if_reg))
      else $error("Read-only status changed by write");
   irq_gate_a: assert property (!ie_reg |=> !irq_reg)
      else $error("Request raised without enable");
   cfg_dflt_a: assert property (core_clr |=> pin0ss_reg == rbc_pkg::PIN0SS_RST
      && pinfn1_reg == rbc_pkg::PINFN1_RST)
      else $error("Config field not at default in reset");

   hard_reset_bit_cycle_c: cover property (hard_reset_bit_fall ##[1:300] boot_req_reg.valid);
   dnv_entry_c: cover property ($rose(dnv_reg));
   boot_done_c: cover property (boot_req_reg.valid ##[1:50] boot_done_reg);
   soft_reset_bit_c: cover property (boot_done_reg ##1 soft_reset_bit_reg);
endmodule // rbc_top

// >>> verif/rbc_loader_model.sv
// Image loader model answering boot requests after a set delay
module rbc_loader_model (
   input wire logic clk_sys,
   input wire logic rst_b,
   input rbc_pkg::rbc_boot_req_t boot_req,
   input wire logic [7:0] dly,
   output logic boot_applied
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   // Applied only while a run is requested, as a one-cycle pulse
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
         boot_applied <= 1'b0;
      end else if (boot_req.valid && !boot_applied) begin
         if (cnt >= dly) begin
            boot_applied <= 1'b1;
            cnt <= 8'h00;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end else begin
         boot_applied <= 1'b0;
         cnt <= 8'h00;
      end
   end
endmodule // rbc_loader_model

// >>> verif/reset_and_boot_config_control_test.sv
// Testbench for the reset and boot control block
module reset_and_boot_config_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   rbc_pkg::rbc_pins_t pins = '0;
   rbc_pkg::rbc_host_req_t host = '0;
   logic [7:0] dly = 8'h14;
   logic boot_applied, rd_valid, rd_refused, miso_oe, boot_done, irq_req;
   logic [7:0] rd_data;
   rbc_pkg::rbc_boot_req_t boot_req, rom_req;
   rbc_pkg::rbc_nvm_wr_t nvm_wr, nvm_seen;
   int errors = 0;
   int num_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   rbc_top #(.INT_NVM(1'b1)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .pins(pins),
      .host(host), .boot_applied(boot_applied), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_refused(rd_refused), .boot_req(boot_req), .nvm_wr(nvm_wr), .miso_oe(miso_oe),
      .boot_done(boot_done), .irq_req(irq_req));
   // ROM part only shows which source it picks
   rbc_top #(.INT_NVM(1'b0)) dut_rom (.clk_sys(clk_sys), .rst_b(rst_b), .pins(pins),
      .host('0), .boot_applied(1'b0), .rd_data(), .rd_valid(), .rd_refused(),
      .boot_req(rom_req), .nvm_wr(), .miso_oe(), .boot_done(), .irq_req());
   rbc_loader_model loader (.clk_sys(clk_sys), .rst_b(rst_b), .boot_req(boot_req),
      .dly(dly), .boot_applied(boot_applied));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Every access starts and ends just after a falling edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      host.wr = 1'b1;
      host.addr = a;
      host.wdata = d;
      cyc(1);
      nvm_seen = nvm_wr;
      host = '0;
      cyc(1);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic refuse);
      host.rd = 1'b1;
      host.addr = a;
      cyc(1);
      chk("read answer", {rd_valid, rd_refused, rd_data}, {~refuse, refuse, exp});
      host = '0;
      cyc(1);
   endtask

   task automatic do_reset(input logic t, input logic [2:0] c, input logic [1:0] f,
                           input int hold);
      rst_b = 1'b0;
      pins.test = t;
      pins.cfg_sel = c;
      pins.if_sel = f;
      cyc(hold);
      chk("outputs in reset", {boot_done, irq_req, miso_oe, boot_req.valid}, 4'h0);
      rst_b = 1'b1;
   endtask

   task automatic wait_done();
      for (int i = 0; i < 400; i++) begin
         if (boot_done === 1'b1) break;
         cyc(1);
      end
      chk("boot_done", boot_done, 1'b1);
   endtask

   initial begin
      rbc_pkg::rbc_src_t rs;
      cyc(1);
      do_reset(1'b0, 3'h5, 2'h1, 8);
      cyc(1);
      chk("boot early", boot_req.valid, 1'b0);
      cyc(1);
      chk("boot req", boot_req, {1'b1, rbc_pkg::RBC_SRC_INT, 3'h5});
      wait_done();
      // Host holds off configuring for 100 us
      cyc(20000);
      rd(rbc_pkg::ADDR_GLOB, 8'h81, 1'b0);
      rd(rbc_pkg::ADDR_CONFIG_STATUS_REG, 8'h45, 1'b0);
      wr(rbc_pkg::ADDR_CONFIG_STATUS_REG, 8'hf7);
      rd(rbc_pkg::ADDR_CONFIG_STATUS_REG, 8'h45, 1'b0);
      wr(rbc_pkg::ADDR_GLOB, 8'h00);
      rd(rbc_pkg::ADDR_GLOB, 8'h81, 1'b0);
      chk("irq no enable", irq_req, 1'b0);
      wr(rbc_pkg::ADDR_GLOB, 8'h02);
      cyc(1);
      chk("irq enabled", irq_req, 1'b1);
      rd(rbc_pkg::ADDR_GLOB, 8'h83, 1'b0);
      wr(rbc_pkg::ADDR_GLOB, 8'h03);
      rd(rbc_pkg::ADDR_GLOB, 8'h82, 1'b0);
      chk("irq cleared", irq_req, 1'b0);
      rd(rbc_pkg::ADDR_SLAVE, {1'b0, rbc_pkg::SLAVE_RST}, 1'b0);
      wr(rbc_pkg::ADDR_SLAVE, 8'h2a);
      wr(rbc_pkg::ADDR_PIN0SS, 8'h1f);
      wr(rbc_pkg::ADDR_PINFN1, 8'h04);
      rd(rbc_pkg::ADDR_PIN0SS, 8'h1f, 1'b0);
      rd(rbc_pkg::ADDR_PINFN1, 8'h04, 1'b0);
      // Straps move just before the hard reset bit is set
      pins.test = 1'b1;
      pins.cfg_sel = 3'h3;
      pins.if_sel = 2'h2;
      wr(rbc_pkg::ADDR_MAIN_CONTROL_ONE, 8'h40);
      chk("done in hard reset", {boot_done, boot_req.valid}, 2'h0);
      rd(rbc_pkg::ADDR_GLOB, 8'h00, 1'b1);
      wr(rbc_pkg::ADDR_MAIN_CONTROL_ONE, 8'h00);
      cyc(200);
      chk("boot before 1 us", boot_req.valid, 1'b0);
      cyc(1);
      chk("boot after delay", boot_req, {1'b1, rbc_pkg::RBC_SRC_INT, 3'h3});
      wait_done();
      rd(rbc_pkg::ADDR_CONFIG_STATUS_REG, 8'h63, 1'b0);
      rd(rbc_pkg::ADDR_SLAVE, 8'h2a, 1'b0);
      rd(rbc_pkg::ADDR_PIN0SS, 8'h00, 1'b0);
      rd(rbc_pkg::ADDR_GLOB, 8'h81, 1'b0);
      chk("irq after hard", irq_req, 1'b0);
      wr(rbc_pkg::ADDR_PIN0SS, 8'h1f);
      wr(rbc_pkg::ADDR_MAIN_CONTROL_ONE, 8'h80);
      chk("done in soft reset", boot_done, 1'b0);
      rd(rbc_pkg::ADDR_CONFIG_STATUS_REG, 8'h63, 1'b0);
      rd(rbc_pkg::ADDR_SLAVE, 8'h2a, 1'b0);
      wr(rbc_pkg::ADDR_MAIN_CONTROL_ONE, 8'h00);
      cyc(300);
      chk("no boot on soft", {boot_req.valid, boot_done}, 2'h0);
      rd(rbc_pkg::ADDR_PIN0SS, 8'h00, 1'b0);
      rd(rbc_pkg::ADDR_GLOB, 8'h00, 1'b0);
      // Each image index, both interface pin sets on the ROM part
      dly = 8'h00;
      for (int i = 0; i < 8; i++) begin
         // Board holds reset low for 1 us each time
         do_reset(1'b0, i[2:0], i[1:0], 200);
         cyc(3);
         chk("image", boot_req, {1'b1, rbc_pkg::RBC_SRC_INT, i[2:0]});
         rs = (i[1:0] == 2'h3) ? rbc_pkg::RBC_SRC_EXT : rbc_pkg::RBC_SRC_ROM;
         chk("rom source", rom_req, {1'b1, rs, i[2:0]});
      end
      do_reset(1'b1, rbc_pkg::AC_DNV, rbc_pkg::IF_EXT_NVM, 200);
      cyc(3);
      chk("direct mode", {miso_oe, boot_done, boot_req.valid}, 3'h6);
      wr(16'h0123, 8'h5a);
      chk("memory write", nvm_seen, {1'b1, 16'h0123, 8'h5a});
      rd(rbc_pkg::ADDR_GLOB, 8'h00, 1'b1);
      cyc(20);
      chk("miso held", miso_oe, 1'b1);
      do_reset(1'b0, 3'h0, 2'h3, 200);
      cyc(3);
      chk("direct mode left", miso_oe, 1'b0);
      results();
   end

   // Tests take about 23000 cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      results();
   end
endmodule // reset_and_boot_config_control_test
